// ### rtl/frame_crc_engine.sv
/*
  ahb-lite register slave, serial transmit framer with crc append,
  modulation pulse and burst length decode, and receive crc checker.
  assumes single word transfers, one etu counter on hclk, and bytes
  from the transmit source offered before each byte boundary.
*/
// Function
// (R01) crc kind code 0 is crc5, 1 crc8, 2 crc16; 3 reserved
// (R02) transmit append bit set appends computed crc to outgoing frame
// (R03) transmit complement bit inverts the crc before it is sent
// (R04) crc16 presets: 0000, 6363, a671, fffe, ffff for codes 0,1,2,3,7
// (R05) crc8 presets 00,12,bf,fd,ff; crc5 presets 00,12,1f
// (R06) preset code 6 selects user value; codes 4 and 5 unused
// (R07) user presets come from nonvolatile configuration inputs
// (R08) receive preset codes map exactly like transmit presets
// (R09) store bit copies received crc bytes out; else only checked
// (R10) software sets store bit when received crc is not byte aligned
// (R11) receive complement bit checks against inverted crc
// (R12) check bit set flags mismatch; clear leaves flag unchanged
// (R13) grid bit keeps frame starts on whole etu multiples
// (R14) payload bit clear sends one symbol pattern only, no data
// (R15) last byte count sends that many low bits; zero sends eight
// (R16) modulation pulse lasts width register plus one clocks
// (R17) pulse cut at bit end; start set by pulse start kind
// (R18) pulse width used only with miller; also for start/stop symbols
// (R19) burst sizes: symbol one bits 6..4, symbol zero bits 2..0
// (R20) burst codes 0..7 give 8,16,32,48,64,96,128,256 bits
// (R21) crc sent right after last data bit, lsb first
`include "frame_crc_regs.svh"

module frame_crc_engine (
  input wire logic hclk, // bus clock
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  input wire logic [15:0] nv_preset16, // user crc16 preset
  input wire logic [7:0] nv_preset8, // user crc8 preset
  input wire logic [4:0] nv_preset5, // user crc5 preset
  input wire logic tx_start, // start frame pulse
  input wire logic tx_byte_valid, // byte offered
  input wire logic [7:0] tx_byte_data, // byte value
  input wire logic tx_byte_last, // byte is final
  output logic tx_byte_ready, // byte taken
  output logic tx_bit, // serial bit, lsb first
  output logic tx_bit_strobe, // one pulse per bit
  output logic tx_symbol, // symbol-only pattern
  output logic tx_pulse, // modulation pulse
  input wire logic miller_on, // miller modulation in use
  input wire logic pulse_start_kind, // 0 bit start, 1 mid bit
  output logic [8:0] symbol_one_burst_size, // burst bits
  output logic [8:0] symbol_zero_burst_size, // burst bits
  input wire logic rx_bit_valid, // received bit strobe
  input wire logic rx_bit, // received bit
  input wire logic rx_frame_end, // frame end pulse
  output logic [15:0] rx_crc_bytes, // received crc field
  output logic rx_crc_store_valid, // crc field offered
  output logic rx_crc_error // sticky mismatch flag
);
  // ========================================================
  // functions
  function automatic frame_crc_pkg::crc_t crc_step(
    input logic [1:0] kind, input frame_crc_pkg::crc_t c, input logic b);
    logic fb;
    frame_crc_pkg::crc_t p;
    fb = c[0] ^ b;
    p = (kind == `KIND_CRC16) ? `POLY16 :
        (kind == `KIND_CRC8) ? `POLY8 : `POLY5; // R01
    crc_step = fb ? ((c >> 1) ^ p) : (c >> 1);
  endfunction : crc_step

  function automatic logic [4:0] crc_width(input logic [1:0] kind);
    crc_width = (kind == `KIND_CRC16) ? `WIDTH16 :
                (kind == `KIND_CRC8) ? `WIDTH8 : `WIDTH5; // R01
  endfunction : crc_width

  function automatic frame_crc_pkg::crc_t crc_preset(
    input logic [1:0] kind, input logic [2:0] sel,
    input logic [15:0] u16, input logic [7:0] u8, input logic [4:0] u5);
    frame_crc_pkg::crc_t v16, v8, v5;
    case (sel) // R04 R05 R06
      3'h0: begin v16 = 16'h0000; v8 = 16'h0000; v5 = 16'h0000; end
      3'h1: begin v16 = 16'h6363; v8 = 16'h0012; v5 = 16'h0012; end
      3'h2: begin v16 = 16'ha671; v8 = 16'h00bf; v5 = 16'h0000; end
      3'h3: begin v16 = 16'hfffe; v8 = 16'h00fd; v5 = 16'h0000; end
      `PRE_USER: begin // R07
        v16 = u16; v8 = {8'h00, u8}; v5 = {11'h000, u5};
      end
      3'h7: begin v16 = 16'hffff; v8 = 16'h00ff; v5 = 16'h001f; end
      default: begin v16 = 16'h0000; v8 = 16'h0000; v5 = 16'h0000; end
    endcase
    crc_preset = (kind == `KIND_CRC16) ? v16 :
                 (kind == `KIND_CRC8) ? v8 : v5;
  endfunction : crc_preset

  function automatic logic [8:0] burst_bits(input logic [2:0] code);
    case (code) // R20
      3'h0: burst_bits = 9'h008;
      3'h1: burst_bits = 9'h010;
      3'h2: burst_bits = 9'h020;
      3'h3: burst_bits = 9'h030;
      3'h4: burst_bits = 9'h040;
      3'h5: burst_bits = 9'h060;
      3'h6: burst_bits = 9'h080;
      default: burst_bits = 9'h100;
    endcase
  endfunction : burst_bits

  // ========================================================
  // ahb-lite slave, zero wait states
  logic [7:0] tx_crc_setup, rx_crc_setup, tx_last_byte_control;
  logic [7:0] tx_pulse_width, tx_burst_length;
  logic wr_pend;
  logic [7:0] wr_idx;
  frame_crc_pkg::tx_state_e state;
  wire addr_ok = haddr[1:0] == 2'h0;
  wire take = hsel && hready && htrans[1];
  wire [7:0] a_idx = haddr[9:2];
  wire w_tx = wr_pend && wr_idx == `IDX_TX_CRC_SETUP;
  wire w_rx = wr_pend && wr_idx == `IDX_RX_CRC_SETUP;
  wire w_last = wr_pend && wr_idx == `IDX_TX_LAST_BYTE;
  wire w_width = wr_pend && wr_idx == `IDX_TX_PULSE_WIDTH;
  wire w_burst = wr_pend && wr_idx == `IDX_TX_BURST_LENGTH;
  wire w_stat = wr_pend && wr_idx == `IDX_FRAME_STATUS;
  wire busy = state != frame_crc_pkg::st_idle;
  wire [7:0] status = {6'h00, busy, rx_crc_error};
  wire [7:0] rd_sel =
    (a_idx == `IDX_TX_CRC_SETUP) ? tx_crc_setup :
    (a_idx == `IDX_RX_CRC_SETUP) ? rx_crc_setup :
    (a_idx == `IDX_TX_LAST_BYTE) ? tx_last_byte_control :
    (a_idx == `IDX_TX_PULSE_WIDTH) ? tx_pulse_width :
    (a_idx == `IDX_TX_BURST_LENGTH) ? tx_burst_length :
    (a_idx == `IDX_FRAME_STATUS) ? status : 8'h00;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      wr_pend <= take && hwrite && addr_ok;
      wr_idx <= a_idx;
      if (take && !hwrite)
        hrdata <= {24'h000000, addr_ok ? rd_sel : 8'h00};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_crc_setup <= `RST_TX_CRC;
      rx_crc_setup <= `RST_RX_CRC;
      tx_last_byte_control <= `RST_LAST;
      tx_pulse_width <= `RST_WIDTH;
      tx_burst_length <= `RST_BURST;
    end else begin
      if (w_tx) tx_crc_setup <= hwdata[7:0] & `MASK_TX_CRC;
      if (w_rx) rx_crc_setup <= hwdata[7:0];
      if (w_last) tx_last_byte_control <= hwdata[7:0] & `MASK_LAST;
      if (w_width) tx_pulse_width <= hwdata[7:0];
      if (w_burst) tx_burst_length <= hwdata[7:0] & `MASK_BURST;
    end
  end

  // ========================================================
  // field decode
  wire tx_crc_append_on = tx_crc_setup[`F_APPEND];
  wire tx_crc_complement = tx_crc_setup[`F_COMPL];
  wire [1:0] tx_crc_kind = tx_crc_setup[`F_KIND_HI:`F_KIND_LO];
  wire [2:0] tx_crc_preset_select = tx_crc_setup[`F_PRE_HI:`F_PRE_LO];
  wire rx_crc_check_on = rx_crc_setup[`F_APPEND];
  wire rx_crc_complement = rx_crc_setup[`F_COMPL];
  wire [1:0] rx_crc_kind = rx_crc_setup[`F_KIND_HI:`F_KIND_LO];
  wire [2:0] rx_crc_preset_select = rx_crc_setup[`F_PRE_HI:`F_PRE_LO];
  wire rx_crc_store_on = rx_crc_setup[`F_STORE];
  wire [2:0] final_byte_bit_count =
    tx_last_byte_control[`F_LAST_HI:`F_LAST_LO];
  wire send_payload_on = tx_last_byte_control[`F_PAYLOAD];
  wire hold_etu_grid = tx_last_byte_control[`F_GRID];
  wire [7:0] pulse_length_count = tx_pulse_width;
  assign symbol_one_burst_size =
    burst_bits(tx_burst_length[`F_B1_HI:`F_B1_LO]); // R19
  assign symbol_zero_burst_size =
    burst_bits(tx_burst_length[`F_B0_HI:`F_B0_LO]); // R19

  // ========================================================
  // etu counter: free running while the grid bit is set, so grid starts stay aligned
  logic [11:0] etu_cnt;
  wire etu_end = etu_cnt == 12'(`ETU_CYCLES - 1);
  wire grid_restart = tx_start && !hold_etu_grid &&
    state == frame_crc_pkg::st_idle; // R13

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) etu_cnt <= 12'h000;
    else if (etu_end || grid_restart) etu_cnt <= 12'h000;
    else etu_cnt <= etu_cnt + 12'h001;
  end

  // ========================================================
  // transmit framer
  logic [7:0] tx_sh;
  logic [2:0] bit_idx;
  logic [4:0] crc_idx;
  logic byte_last;
  frame_crc_pkg::crc_t tx_crc;
  wire [2:0] last_top = final_byte_bit_count - 3'h1; // R15
  wire byte_done = byte_last ? (bit_idx == last_top) : (bit_idx == 3'h7);
  wire go = etu_end || !hold_etu_grid; // R13
  wire align_go = state == frame_crc_pkg::st_align && etu_end;
  wire data_tick = state == frame_crc_pkg::st_data && etu_end;
  assign tx_byte_ready = (align_go && send_payload_on) ||
    (data_tick && byte_done && !byte_last);
  wire load_byte = tx_byte_ready && tx_byte_valid;
  wire frame_over = data_tick && byte_done &&
    (byte_last || !tx_byte_valid);
  frame_crc_pkg::crc_t tx_crc_out;
  assign tx_crc_out = tx_crc_complement ? ~tx_crc : tx_crc; // R03

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) state <= frame_crc_pkg::st_idle;
    else begin
      case (state)
        frame_crc_pkg::st_idle:
          if (tx_start) state <= go && grid_restart ?
            frame_crc_pkg::st_align : frame_crc_pkg::st_align;
        frame_crc_pkg::st_align:
          if (etu_end) state <= !send_payload_on ?
            frame_crc_pkg::st_symbol : // R14
            tx_byte_valid ? frame_crc_pkg::st_data :
            frame_crc_pkg::st_idle;
        frame_crc_pkg::st_data:
          if (frame_over) state <= tx_crc_append_on ?
            frame_crc_pkg::st_crc : frame_crc_pkg::st_idle; // R02 R21
        frame_crc_pkg::st_crc:
          if (etu_end && crc_idx == crc_width(tx_crc_kind) - 5'h01)
            state <= frame_crc_pkg::st_idle;
        frame_crc_pkg::st_symbol:
          if (etu_end) state <= frame_crc_pkg::st_idle;
        default: state <= frame_crc_pkg::st_idle;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_sh <= 8'h00;
      bit_idx <= 3'h0;
      crc_idx <= 5'h00;
      byte_last <= 1'b0;
      tx_crc <= 16'h0000;
    end else begin
      if (state == frame_crc_pkg::st_idle) begin
        tx_crc <= crc_preset(tx_crc_kind, tx_crc_preset_select,
          nv_preset16, nv_preset8, nv_preset5); // R04 R05 R06
        crc_idx <= 5'h00;
      end
      if (load_byte) begin
        tx_sh <= tx_byte_data;
        byte_last <= tx_byte_last;
        bit_idx <= 3'h0;
      end else if (data_tick) begin
        tx_sh <= tx_sh >> 1; // R15
        bit_idx <= bit_idx + 3'h1;
      end
      if (data_tick)
        tx_crc <= crc_step(tx_crc_kind, tx_crc, tx_sh[0]);
      if (state == frame_crc_pkg::st_crc && etu_end)
        crc_idx <= crc_idx + 5'h01; // R21
    end
  end

  // bit output registered at each etu start
  wire send_bit = data_tick || (state == frame_crc_pkg::st_crc && etu_end);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_bit <= 1'b0;
      tx_bit_strobe <= 1'b0;
      tx_symbol <= 1'b0;
    end else begin
      tx_bit_strobe <= send_bit;
      if (data_tick) tx_bit <= tx_sh[0]; // R21
      else if (state == frame_crc_pkg::st_crc && etu_end)
        tx_bit <= tx_crc_out[crc_idx[3:0]]; // R02 R21
      if (state == frame_crc_pkg::st_align && etu_end)
        tx_symbol <= !send_payload_on; // R14
      else if (state == frame_crc_pkg::st_symbol && etu_end)
        tx_symbol <= 1'b0;
    end
  end

  // ========================================================
  // modulation pulse: from start position, width+1 clocks,
  // truncated where the etu counter wraps at bit end
  wire [11:0] pulse_base = pulse_start_kind ?
    12'(`MID_BIT) : 12'h000; // R17
  wire [11:0] pulse_off = etu_cnt - pulse_base;
  wire in_bit = state == frame_crc_pkg::st_data ||
    state == frame_crc_pkg::st_crc || state == frame_crc_pkg::st_symbol;
  wire pause_bit = tx_symbol || !tx_bit; // R18
  wire next_pulse = miller_on && in_bit && pause_bit && // R18
    etu_cnt >= pulse_base &&
    pulse_off <= {4'h0, pulse_length_count}; // R16 R17
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tx_pulse <= 1'b0;
    else tx_pulse <= next_pulse && !etu_end; // R17
  end

  // ========================================================
  // receive checker: crc runs over bits leaving a window that
  // holds the last crc-width bits, which are the received crc
  frame_crc_pkg::crc_t rx_crc, rx_win;
  logic [4:0] rx_fill;
  logic rx_active;
  wire [4:0] rx_w = crc_width(rx_crc_kind);
  wire win_full = rx_fill == rx_w;
  wire [15:0] win_mask = 16'((17'h00001 << rx_w) - 17'h00001);
  frame_crc_pkg::crc_t rx_expect;
  assign rx_expect = (rx_crc_complement ? ~rx_crc : rx_crc) &
    win_mask; // R11
  wire [3:0] top = rx_w[3:0] - 4'h1;
  wire mismatch = rx_active && rx_expect != (rx_win & win_mask);
  wire set_err = rx_frame_end && rx_crc_check_on && mismatch; // R12
  wire clr_err = w_stat && hwdata[`F_ST_ERR];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_crc <= 16'h0000;
      rx_win <= 16'h0000;
      rx_fill <= 5'h00;
      rx_active <= 1'b0;
    end else if (rx_frame_end) begin
      rx_crc <= crc_preset(rx_crc_kind, rx_crc_preset_select,
        nv_preset16, nv_preset8, nv_preset5); // R08
      rx_fill <= 5'h00;
      rx_active <= 1'b0;
    end else if (rx_bit_valid) begin
      rx_active <= 1'b1;
      if (!rx_active)
        rx_crc <= crc_preset(rx_crc_kind, rx_crc_preset_select,
          nv_preset16, nv_preset8, nv_preset5); // R08
      else if (win_full)
        rx_crc <= crc_step(rx_crc_kind, rx_crc, rx_win[0]);
      // mask drops bits left above the window by a wider crc kind
      rx_win <= ((rx_win >> 1) & (win_mask >> 1)) | (16'(rx_bit) << top);
      if (!rx_active) rx_fill <= 5'h01;
      else if (!win_full) rx_fill <= rx_fill + 5'h01;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_crc_error <= 1'b0;
      rx_crc_bytes <= 16'h0000;
      rx_crc_store_valid <= 1'b0;
    end else begin
      if (set_err) rx_crc_error <= 1'b1; // R12
      else if (clr_err) rx_crc_error <= 1'b0;
      rx_crc_store_valid <= rx_frame_end && rx_active &&
        rx_crc_store_on; // R09 R10
      if (rx_frame_end) rx_crc_bytes <= rx_win & win_mask; // R09
    end
  end

  // ========================================================
  // checks
  wire crc_plain_bit = tx_crc[crc_idx[3:0]];
  wire [15:0] p7 = crc_preset(`KIND_CRC16, 3'h7, nv_preset16,
    nv_preset8, nv_preset5);
  preset_table_a: assert property (@(posedge hclk) disable iff (!hresetn)
    p7 == 16'hffff) else $error("crc16 code 7 preset wrong"); // R04
  crc_append_a: assert property (@(posedge hclk) disable iff (!hresetn)
    frame_over && tx_crc_append_on |=> state == frame_crc_pkg::st_crc)
    else $error("crc not appended after data"); // R02 R21
  no_append_a: assert property (@(posedge hclk) disable iff (!hresetn)
    frame_over && !tx_crc_append_on |=> state == frame_crc_pkg::st_idle)
    else $error("crc sent while disabled"); // R02
  crc_invert_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state == frame_crc_pkg::st_crc && etu_end |=>
    tx_bit == ($past(tx_crc_complement) ^ $past(crc_plain_bit)))
    else $error("crc bit polarity wrong"); // R03
  symbol_only_a: assert property (@(posedge hclk) disable iff (!hresetn)
    align_go && !send_payload_on |=> tx_symbol && !tx_byte_ready)
    else $error("payload sent in symbol mode"); // R14
  grid_start_a: assert property (@(posedge hclk) disable iff (!hresetn)
    state == frame_crc_pkg::st_idle && tx_start && hold_etu_grid |=>
    state == frame_crc_pkg::st_align &&
    (etu_cnt != 12'h000 || $past(etu_end)))
    else $error("grid start moved the etu counter"); // R13
  err_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    !rx_crc_check_on && !clr_err |=> rx_crc_error == $past(rx_crc_error))
    else $error("error flag changed while check off"); // R12
  err_set_a: assert property (@(posedge hclk) disable iff (!hresetn)
    set_err |=> rx_crc_error) else $error("mismatch not flagged"); // R12
  store_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
    rx_crc_store_valid |-> $past(rx_crc_store_on))
    else $error("crc stored while store off"); // R09
  pulse_len_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_pulse |-> $past(pulse_off) <= {4'h0, $past(pulse_length_count)}
    && $past(miller_on)) else $error("pulse too long"); // R16 R18
  burst_map_a: assert property (@(posedge hclk) disable iff (!hresetn)
    tx_burst_length[`F_B1_HI:`F_B1_LO] == 3'h7 |->
    symbol_one_burst_size == 9'h100)
    else $error("burst code 7 not 256 bits"); // R20
endmodule : frame_crc_engine

// ### shared/frame_crc_pkg.sv
/*
  types shared by the frame crc block.
  assumes frame_crc_regs.svh is compiled alongside.
*/
package frame_crc_pkg;
  typedef enum logic [2:0] {
    st_idle, st_align, st_data, st_crc, st_symbol
  } tx_state_e;
  typedef logic [15:0] crc_t;
endpackage : frame_crc_pkg

// ### shared/frame_crc_regs.svh
/*
  register map, field positions, reset values and timing counts of the
  frame crc and transmit data block.
  assumes a 32-bit ahb-lite bus, one register per aligned word.
*/
`ifndef FRAME_CRC_REGS_SVH
`define FRAME_CRC_REGS_SVH

// ==========================================================
// register indices; byte address is four times the index
`define IDX_TX_CRC_SETUP 8'h2c
`define IDX_RX_CRC_SETUP 8'h2d
`define IDX_TX_LAST_BYTE 8'h2e
`define IDX_TX_PULSE_WIDTH 8'h2f
`define IDX_TX_BURST_LENGTH 8'h30
`define IDX_FRAME_STATUS 8'h3f

// ==========================================================
// field positions
`define F_APPEND 0
`define F_COMPL 1
`define F_KIND_LO 2
`define F_KIND_HI 3
`define F_PRE_LO 4
`define F_PRE_HI 6
`define F_STORE 7
`define F_LAST_LO 0
`define F_LAST_HI 2
`define F_PAYLOAD 3
`define F_GRID 4
`define F_B0_LO 0
`define F_B0_HI 2
`define F_B1_LO 4
`define F_B1_HI 6
`define F_ST_ERR 0
`define F_ST_BUSY 1

// ==========================================================
// reset values and write masks
`define RST_TX_CRC 8'h00
`define RST_RX_CRC 8'h00
`define RST_LAST 8'h08
`define RST_WIDTH 8'h00
`define RST_BURST 8'h00
`define MASK_TX_CRC 8'h7f
`define MASK_LAST 8'h1f
`define MASK_BURST 8'h77

// ==========================================================
// crc kinds, preset codes, polynomials (lsb-first form)
`define KIND_CRC5 2'h0
`define KIND_CRC8 2'h1
`define KIND_CRC16 2'h2
`define PRE_USER 3'h6
`define POLY5 16'h0014
`define POLY8 16'h00b8
`define POLY16 16'h8408
`define WIDTH5 5'h05
`define WIDTH8 5'h08
`define WIDTH16 5'h10

// ==========================================================
// timing: one etu in ns and in 8 ns clocks
`define CLK_MHZ 125
`define ETU_NS 9440
`define ETU_CYCLES ((`ETU_NS * `CLK_MHZ) / 1000)
`define MID_BIT (`ETU_CYCLES / 2)

`endif

// ### verification/rf_card_model.sv
/*
  card side of the rf link: records sent bits, plays received frames.
  assumes one hclk domain and lsb-first bits on both directions.
*/
module rf_card_model (
  input wire logic hclk, // clock
  input wire logic tx_bit, // sent bit
  input wire logic tx_bit_strobe, // one pulse per sent bit
  output logic rx_bit_valid, // bit strobe to reader
  output logic rx_bit, // bit to reader
  output logic rx_frame_end // frame close pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] got = '0;
  int n_got = 0;
  initial begin
    rx_bit_valid = 1'b0;
    rx_bit = 1'b0;
    rx_frame_end = 1'b0;
  end
  always @(posedge hclk) begin
    if (tx_bit_strobe) begin
      got[n_got[4:0]] <= tx_bit;
      n_got <= n_got + 1;
    end
  end
  // ==========================================================
  // frame playback; line shows the inverse bit between strobes
  task automatic send(input logic [31:0] bits, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge hclk) rx_bit_valid <= 1'b1;
      rx_bit <= bits[i];
      @(posedge hclk) rx_bit_valid <= 1'b0;
      rx_bit <= ~bits[i];
    end
    @(posedge hclk) rx_frame_end <= 1'b1;
    @(posedge hclk) rx_frame_end <= 1'b0;
  endtask : send
endmodule : rf_card_model

// ### verification/rf_frame_crc_and_tx_data_config_bench.sv
/*
  self-checking bench of the frame crc engine.
  assumes the card model beside it and a single 125 mhz clock.
*/
`include "frame_crc_regs.svh"
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin \
  mismatches++; $display("MISMATCH %0t got %h want %h", $time, a, e); \
  end end
module rf_frame_crc_and_tx_data_config_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
  logic [1:0] htrans = '0;
  logic [15:0] nv_preset16 = '0, rx_crc_bytes, c;
  logic tx_start = 0, tx_byte_valid = 0, tx_byte_last = 0;
  logic [7:0] tx_byte_data = '0;
  logic tx_byte_ready, tx_bit, tx_bit_strobe, tx_symbol, tx_pulse;
  logic [8:0] symbol_one_burst_size, symbol_zero_burst_size;
  logic rx_bit_valid, rx_bit, rx_frame_end, rx_crc_store_valid;
  logic rx_crc_error;
  int mismatches = 0, n_compared = 0;
  // addr, reset value, write value, read back; c4 is unmapped
  logic [31:0] rows [6] = '{32'hb000ff7f, 32'hb400ffff,
    32'hb808ff1f, 32'hbc00ffff, 32'hc000ff77, 32'hc400ff00};
  logic [8:0] blen [8] = '{9'h008, 9'h010, 9'h020, 9'h030,
    9'h040, 9'h060, 9'h080, 9'h100};
  always #4 hclk = ~hclk;
  frame_crc_engine u_frame_crc_engine (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .nv_preset16(nv_preset16),
    .nv_preset8(8'h00), .nv_preset5(5'h00), .tx_start(tx_start),
    .tx_byte_valid(tx_byte_valid), .tx_byte_data(tx_byte_data),
    .tx_byte_last(tx_byte_last), .tx_byte_ready(tx_byte_ready),
    .tx_bit(tx_bit), .tx_bit_strobe(tx_bit_strobe),
    .tx_symbol(tx_symbol), .tx_pulse(tx_pulse), .miller_on(1'b1),
    .pulse_start_kind(1'b0),
    .symbol_one_burst_size(symbol_one_burst_size),
    .symbol_zero_burst_size(symbol_zero_burst_size),
    .rx_bit_valid(rx_bit_valid), .rx_bit(rx_bit),
    .rx_frame_end(rx_frame_end), .rx_crc_bytes(rx_crc_bytes),
    .rx_crc_store_valid(rx_crc_store_valid), .rx_crc_error(rx_crc_error));
  rf_card_model u_rf_card_model (.hclk(hclk), .tx_bit(tx_bit),
    .tx_bit_strobe(tx_bit_strobe), .rx_bit_valid(rx_bit_valid),
    .rx_bit(rx_bit), .rx_frame_end(rx_frame_end));
  // ==========================================================
  // helpers
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus
  function automatic logic [15:0] step(input logic [1:0] k,
      input logic [15:0] v, input logic b);
    logic [15:0] p;
    p = (k == 2'h0) ? `POLY5 : (k == 2'h1) ? `POLY8 : `POLY16;
    return (v >> 1) ^ ((v[0] ^ b) ? p : 16'h0);
  endfunction : step
  task automatic start_frame();
    @(posedge hclk) tx_start <= 1'b1;
    @(posedge hclk) tx_start <= 1'b0;
  endtask : start_frame
  task automatic rx_case(input logic [7:0] s, input logic [15:0] pre,
      input logic bad, input logic err);
    int w;
    w = (s[3:2] == 2'h0) ? 5 : (s[3:2] == 2'h1) ? 8 : 16;
    c = pre;
    for (int i = 0; i < 8; i++) c = step(s[3:2], c, 8'h5a >> i);
    c = ((s[1] ? ~c : c) ^ {15'h0, bad}) & 16'((32'h1 << w) - 1);
    bus(1'b1, 8'hb4, {24'h0, s});
    u_rf_card_model.send({8'h0, c, 8'h5a}, 8 + w);
    @(negedge hclk);
    `CHK(rx_crc_error, err)
    `CHK(rx_crc_store_valid, s[7])
    if (s[7]) `CHK(rx_crc_bytes, c)
    bus(1'b1, 8'hfc, 32'h1);
  endtask : rx_case
  task automatic conclude();
    if (mismatches == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : conclude
  // ==========================================================
  // sequence
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, rows[i][31:24], 32'h0);
      `CHK(q, {24'h0, rows[i][23:16]})
      bus(1'b1, rows[i][31:24], {24'h0, rows[i][15:8]});
      bus(1'b0, rows[i][31:24], 32'h0);
      `CHK(q, {24'h0, rows[i][7:0]})
    end
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, 8'hc0, {25'h0, i[2:0], 1'b0, 3'(7 - i)});
      @(negedge hclk);
      `CHK(symbol_one_burst_size, blen[i])
      `CHK(symbol_zero_burst_size, blen[7 - i])
    end
    nv_preset16 <= 16'h1234;
    rx_case(8'h99, 16'h6363, 1'b0, 1'b0);
    rx_case(8'h99, 16'h6363, 1'b1, 1'b1);
    rx_case(8'h98, 16'h6363, 1'b1, 1'b0);
    rx_case(8'h1b, 16'h6363, 1'b0, 1'b0);
    rx_case(8'he9, 16'h1234, 1'b0, 1'b0);
    rx_case(8'ha5, 16'h00bf, 1'b0, 1'b0);
    rx_case(8'hf9, 16'hffff, 1'b0, 1'b0);
    rx_case(8'hf1, 16'h001f, 1'b0, 1'b0);
    // crc5 preset 7, complement, append; three bits of last byte
    bus(1'b1, 8'hb0, 32'h73);
    bus(1'b1, 8'hb8, 32'h0b);
    tx_byte_data <= 8'hb2;
    tx_byte_last <= 1'b1;
    tx_byte_valid <= 1'b1;
    start_frame();
    do @(posedge hclk); while (tx_byte_ready !== 1'b1);
    tx_byte_valid <= 1'b0;
    while (u_rf_card_model.n_got < 8) @(posedge hclk);
    c = 16'h001f;
    for (int i = 0; i < 3; i++) c = step(2'h0, c, 8'hb2 >> i);
    `CHK(u_rf_card_model.got[7:0], {~c[4:0], 3'b010})
    do bus(1'b0, 8'hfc, 32'h0); while (q[1] !== 1'b0);
    bus(1'b1, 8'hb8, 32'h10);
    start_frame();
    for (int k = 0; k < 3000 && tx_symbol !== 1'b1; k++) @(posedge hclk);
    `CHK(tx_symbol, 1'b1)
    `CHK(u_rf_card_model.n_got, 8)
    // width register still holds ff: pulse lasts 256 clocks
    @(negedge hclk);
    `CHK(tx_pulse, 1'b1)
    repeat (256) @(negedge hclk);
    `CHK(tx_pulse, 1'b0)
    conclude();
  end
  initial begin
    repeat (60000) @(posedge hclk);
    mismatches++;
    conclude();
  end
endmodule : rf_frame_crc_and_tx_data_config_bench
